// ---- logic/pcmc_regs.vh ----
// Constants for the connection-management monitor counters
`ifndef PCMC_REGS_VH
`define PCMC_REGS_VH
// Line state codes
`define PCMC_LS_ALS 3'h0
`define PCMC_LS_ILS 3'h1
`define PCMC_LS_NSD 3'h2
`define PCMC_LS_ULS 3'h3
`define PCMC_LS_MLS 3'h4
`define PCMC_LS_HLS 3'h5
`define PCMC_LS_QLS 3'h6
`define PCMC_LS_NLS 3'h7
// Symbol codes, 4-bit with control flag
`define PCMC_SYM_V 4'h0
`define PCMC_SYM_H 4'h4
`define PCMC_SYM_T 4'h5
`define PCMC_SYM_R 4'h6
`define PCMC_SYM_S 4'h7
`define PCMC_SYM_I 4'ha
`define PCMC_SYM_J 4'hc
`define PCMC_SYM_K 4'hd
// Indicate codes sourced while scrubbing
`define PCMC_CODE_INVALID 8'h3b
`define PCMC_CODE_SCRUB 8'hb8
// Invalid symbol pairs before scrub pairs
`define PCMC_SCRUB_LEAD 2'h2
// Idle pairs for extended idle, plus one more pair
`define PCMC_IDLE_PAIRS 4'h8
`define PCMC_IDLE_EXTRA 4'h1
// Longest scrub time in microseconds and clock rate in MHz
`define PCMC_SCRUB_MAX_US 10000
`define PCMC_CLK_MHZ 100
`endif

// ---- logic/pcmc_monitor.v ----
// Scrub timer, extended idle, noise counter and link error monitor
`timescale 1ns/100ps
`include "pcmc_regs.vh"

module pcmc_monitor #(
  parameter NC_W = 16,
  parameter NP_W = 8,
  parameter LE_W = 16,
  parameter ST_W = 20,
  parameter CFG_W = 8,
  parameter [ST_W-1:0] SCRUB_RESET = 20'hf4240 // 10 ms at 100 MHz
) (
  // Clock and reset
  input wire REF_CLK_I,
  input wire RST_I,
  // Received byte stream
  input wire [2:0] LINE_STATE_I,
  input wire [3:0] SYM1_I,
  input wire [3:0] SYM2_I,
  input wire SYM1_CTL_I,
  input wire SYM2_CTL_I,
  input wire BYTE_VALID_I,
  input wire STUFFED_BYTE_I,
  input wire SIGNAL_DETECT_I,
  input wire CLOCK_DETECT_I,
  input wire [7:0] INDICATE_I,
  // Trigger and configuration
  input wire TRIGGER_MET_I,
  input wire TRIGGER_FLAG_CLR_I,
  input wire SCRUB_ON_TRIGGER_ENABLE_I,
  input wire [ST_W-1:0] SCRUB_TIME_THRESHOLD_I,
  input wire [CFG_W-1:0] TRIGGER_TRANSITION_CONFIG_I,
  input wire [CFG_W-1:0] CFG_WDATA_I,
  input wire CFG_WRITE_I,
  // Counter thresholds and reload strobes
  input wire [NC_W-1:0] NOISE_COUNT_THRESHOLD_I,
  input wire [NP_W-1:0] NOISE_PRESCALE_THRESHOLD_I,
  input wire [LE_W-1:0] LINK_ERROR_THRESHOLD_I,
  input wire LINK_ERROR_RELOAD_I,
  // Outputs
  output reg [7:0] INDICATE_O,
  output reg SCRUB_ACTIVE_O,
  output reg [7:0] SCRUB_TIME_SNAPSHOT_O,
  output reg TRIGGER_OCCURRED_FLAG_O,
  output reg [CFG_W-1:0] SWITCH_CONFIGURATION_REGISTER_O,
  output reg EXTENDED_IDLE_STATE_O,
  output reg [NC_W-1:0] NOISE_COUNT_SNAPSHOT_O,
  output reg [NP_W-1:0] NOISE_PRESCALE_SNAPSHOT_O,
  output reg NOISE_EXPIRED_O,
  output reg NOISE_EVENT_O,
  output reg [LE_W-1:0] LINK_ERROR_COUNT_SNAPSHOT_O,
  output reg LINK_ERROR_EVENT_O,
  output reg LINK_ERROR_EXHAUSTED_O
);

  // ----------------------------------------------------------------
  // Pin synchronisers for detect levels
  // ----------------------------------------------------------------
  reg sd_meta, sd_sync, cd_meta, cd_sync;
  // Detect pins come from the analog front end, so two flops each
  always @(posedge REF_CLK_I) begin
    sd_meta <= SIGNAL_DETECT_I;
    sd_sync <= sd_meta;
    cd_meta <= CLOCK_DETECT_I;
    cd_sync <= cd_meta;
  end

  // ----------------------------------------------------------------
  // Byte decode
  // ----------------------------------------------------------------
  reg [2:0] prev_line_state;
  reg [2:0] cur_ls;
  reg prev_ii;
  wire is_als = (LINE_STATE_I == `PCMC_LS_ALS);
  wire is_ils = (LINE_STATE_I == `PCMC_LS_ILS);
  wire is_uls = (LINE_STATE_I == `PCMC_LS_ULS);
  wire s1_i = SYM1_CTL_I && (SYM1_I == `PCMC_SYM_I);
  wire s2_i = SYM2_CTL_I && (SYM2_I == `PCMC_SYM_I);
  wire s1_h = SYM1_CTL_I && (SYM1_I == `PCMC_SYM_H);
  wire s2_h = SYM2_CTL_I && (SYM2_I == `PCMC_SYM_H);
  wire s1_v = SYM1_CTL_I && (SYM1_I == `PCMC_SYM_V);
  wire s2_v = SYM2_CTL_I && (SYM2_I == `PCMC_SYM_V);
  wire pair_ii = s1_i && s2_i;
  wire pair_jk = SYM1_CTL_I && SYM2_CTL_I && (SYM1_I == `PCMC_SYM_J) &&
                 (SYM2_I == `PCMC_SYM_K);
  wire pair_hh = s1_h && s2_h;
  wire pair_hi = s1_h && s2_i;
  // Symbol "A": data or R, S, T; "B": A or idle
  wire s1_a = !SYM1_CTL_I || (SYM1_I == `PCMC_SYM_R) || (SYM1_I == `PCMC_SYM_S) ||
              (SYM1_I == `PCMC_SYM_T);
  wire s2_b = !SYM2_CTL_I || (SYM2_I == `PCMC_SYM_R) || (SYM2_I == `PCMC_SYM_S) ||
              (SYM2_I == `PCMC_SYM_T) || (SYM2_I == `PCMC_SYM_I);
  wire pair_ab = s1_a && s2_b;
  wire has_t = (SYM1_CTL_I && SYM1_I == `PCMC_SYM_T) || (SYM2_CTL_I && SYM2_I == `PCMC_SYM_T);
  // Converted-data symbol shows as 0000 data in a mixed byte
  wire s1_n = !SYM1_CTL_I && (SYM1_I == 4'h0) && SYM2_CTL_I;
  wire s1_rst = SYM1_CTL_I && ((SYM1_I == `PCMC_SYM_R) || (SYM1_I == `PCMC_SYM_S) ||
                (SYM1_I == `PCMC_SYM_T));
  // State before this byte; the register only catches up one byte after a change
  wire [2:0] previous_line_state = (LINE_STATE_I != cur_ls) ? cur_ls : prev_line_state;
  // Unknown line state entered from active
  wire uls_from_als = is_uls && (previous_line_state == `PCMC_LS_ALS);
  // Invalid state per line state and history
  wire phy_invalid_state = (LINE_STATE_I == `PCMC_LS_HLS) || (LINE_STATE_I == `PCMC_LS_QLS) ||
    (LINE_STATE_I == `PCMC_LS_MLS) || (LINE_STATE_I == `PCMC_LS_NLS) ||
    (is_uls && ((previous_line_state == `PCMC_LS_ALS) || (previous_line_state == `PCMC_LS_ILS)));

  // Previous line state tracks the last state different from the current one
  always @(posedge REF_CLK_I) begin
    if (RST_I) begin
      cur_ls <= `PCMC_LS_QLS;
      prev_line_state <= `PCMC_LS_QLS;
      prev_ii <= 1'b0;
    end else if (BYTE_VALID_I) begin
      cur_ls <= LINE_STATE_I;
      if (LINE_STATE_I != cur_ls)
        prev_line_state <= cur_ls;
      prev_ii <= pair_ii;
    end
  end

  // ----------------------------------------------------------------
  // Trigger, configuration load and scrubbing
  // ----------------------------------------------------------------
  localparam SC_IDLE = 2'h0;
  localparam SC_LEAD = 2'h1;
  localparam SC_SCRUB = 2'h2;
  localparam SC_LOAD = 2'h3;
  reg [1:0] sc_state;
  reg [1:0] lead_cnt;
  reg [ST_W-1:0] scrub_timer;

  // Scrub sequencer; while scrubbing, the switch changes only after the scrub time ends
  always @(posedge REF_CLK_I) begin
    if (RST_I) begin
      sc_state <= SC_IDLE;
      lead_cnt <= 2'h0;
      scrub_timer <= SCRUB_RESET;
      TRIGGER_OCCURRED_FLAG_O <= 1'b0;
      SWITCH_CONFIGURATION_REGISTER_O <= {CFG_W{1'b0}};
      SCRUB_ACTIVE_O <= 1'b0;
      INDICATE_O <= 8'h00;
      SCRUB_TIME_SNAPSHOT_O <= 8'h00;
    end else begin
      // Set wins over a clear in the same cycle
      if (TRIGGER_MET_I)
        TRIGGER_OCCURRED_FLAG_O <= 1'b1;
      else if (TRIGGER_FLAG_CLR_I)
        TRIGGER_OCCURRED_FLAG_O <= 1'b0;
      SCRUB_TIME_SNAPSHOT_O <= scrub_timer[ST_W-1:ST_W-8];
      case (sc_state)
        SC_IDLE: begin
          SCRUB_ACTIVE_O <= 1'b0;
          INDICATE_O <= INDICATE_I;
          if (TRIGGER_MET_I && SCRUB_ON_TRIGGER_ENABLE_I) begin
            sc_state <= SC_LEAD;
            lead_cnt <= `PCMC_SCRUB_LEAD;
            scrub_timer <= SCRUB_TIME_THRESHOLD_I;
            SCRUB_ACTIVE_O <= 1'b1;
            INDICATE_O <= `PCMC_CODE_INVALID;
          end else if (TRIGGER_MET_I) begin
            sc_state <= SC_LOAD;
          end else if (CFG_WRITE_I) begin
            SWITCH_CONFIGURATION_REGISTER_O <= CFG_WDATA_I;
          end
        end
        SC_LEAD: begin
          // Two invalid symbols, sent one per clock cycle whatever the byte valid
          if (lead_cnt > 2'h1) begin
            lead_cnt <= lead_cnt - 2'h1;
            INDICATE_O <= `PCMC_CODE_INVALID;
          end else begin
            sc_state <= SC_SCRUB;
            INDICATE_O <= `PCMC_CODE_SCRUB;
          end
        end
        SC_SCRUB: begin
          INDICATE_O <= `PCMC_CODE_SCRUB;
          if (scrub_timer == {ST_W{1'b0}})
            sc_state <= SC_LOAD;
          else
            scrub_timer <= scrub_timer - {{(ST_W-1){1'b0}}, 1'b1};
        end
        SC_LOAD: begin
          // Software writes are dropped while the load happens
          SWITCH_CONFIGURATION_REGISTER_O <= TRIGGER_TRANSITION_CONFIG_I;
          SCRUB_ACTIVE_O <= 1'b0;
          INDICATE_O <= INDICATE_I;
          sc_state <= SC_IDLE;
        end
        default: sc_state <= SC_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Extended idle detection
  // ----------------------------------------------------------------
  reg [3:0] idle_cnt;
  // Counts idle pairs up to eight plus one extra; asserts on the pair after that, the tenth
  always @(posedge REF_CLK_I) begin
    if (RST_I) begin
      idle_cnt <= 4'h0;
      EXTENDED_IDLE_STATE_O <= 1'b0;
    end else if (BYTE_VALID_I) begin
      if (!(is_ils && pair_ii)) begin
        idle_cnt <= 4'h0;
        EXTENDED_IDLE_STATE_O <= 1'b0;
      end else if (idle_cnt < (`PCMC_IDLE_PAIRS + `PCMC_IDLE_EXTRA)) begin
        idle_cnt <= idle_cnt + 4'h1;
      end else begin
        EXTENDED_IDLE_STATE_O <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Noise event counter
  // ----------------------------------------------------------------
  reg [NC_W-1:0] noise_cnt;
  reg [NP_W-1:0] noise_pre;
  wire ls_reload = (LINE_STATE_I == `PCMC_LS_HLS) || is_ils || (LINE_STATE_I == `PCMC_LS_MLS) ||
                   (LINE_STATE_I == `PCMC_LS_QLS) || (LINE_STATE_I == `PCMC_LS_NSD) ||
                   !sd_sync;
  wire delim = pair_jk || has_t;
  wire ls_count = (LINE_STATE_I == `PCMC_LS_NLS) || is_uls || is_als;
  // Three noise byte cases
  wire noise_event = (sd_sync && !cd_sync) ||
                     (sd_sync && cd_sync && phy_invalid_state && !(pair_ii || pair_jk || pair_ab)) ||
                     (sd_sync && cd_sync && !phy_invalid_state && prev_ii && pair_ab);

  // Prescaler underflow steps the main count, so period is product
  always @(posedge REF_CLK_I) begin
    if (RST_I) begin
      noise_cnt <= {NC_W{1'b0}};
      noise_pre <= {NP_W{1'b0}};
      NOISE_EXPIRED_O <= 1'b0;
      NOISE_EVENT_O <= 1'b0;
      NOISE_COUNT_SNAPSHOT_O <= {NC_W{1'b0}};
      NOISE_PRESCALE_SNAPSHOT_O <= {NP_W{1'b0}};
    end else begin
      NOISE_EVENT_O <= BYTE_VALID_I && noise_event;
      NOISE_COUNT_SNAPSHOT_O <= noise_cnt;
      NOISE_PRESCALE_SNAPSHOT_O <= noise_pre;
      if (BYTE_VALID_I) begin
        if (ls_reload || delim) begin
          noise_cnt <= NOISE_COUNT_THRESHOLD_I;
          noise_pre <= NOISE_PRESCALE_THRESHOLD_I;
          NOISE_EXPIRED_O <= 1'b0;
        end else if (ls_count && !NOISE_EXPIRED_O) begin
          if (noise_pre != {NP_W{1'b0}}) begin
            noise_pre <= noise_pre - {{(NP_W-1){1'b0}}, 1'b1};
          end else begin
            noise_pre <= NOISE_PRESCALE_THRESHOLD_I;
            if (noise_cnt == {NC_W{1'b0}})
              NOISE_EXPIRED_O <= 1'b1;
            else
              noise_cnt <= noise_cnt - {{(NC_W-1){1'b0}}, 1'b1};
          end
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Link error monitor
  // ----------------------------------------------------------------
  reg link_error_flag;
  reg [LE_W-1:0] le_cnt;
  // Unknown-after-active term skips stuffed bytes
  wire uls_term = uls_from_als && link_error_flag && !STUFFED_BYTE_I &&
                  !(pair_hh || pair_hi || pair_ii || pair_jk);
  // Active and idle state error terms
  wire le_event = (is_als && ((s1_i && !s2_i) || s1_v || s2_v || (s1_h && !s2_h) || !sd_sync)) ||
                  (is_ils && (!(pair_ii || pair_jk) || !sd_sync)) || uls_term;
  wire flag_set = is_als && s2_h && (s1_h || s1_n || s1_rst);
  wire flag_clr = ((is_als || is_ils) && pair_jk) || uls_term;

  // Counter sticks at zero and reports exhaustion until reload
  always @(posedge REF_CLK_I) begin
    if (RST_I) begin
      link_error_flag <= 1'b0;
      le_cnt <= {LE_W{1'b0}};
      LINK_ERROR_EVENT_O <= 1'b0;
      LINK_ERROR_EXHAUSTED_O <= 1'b0;
      LINK_ERROR_COUNT_SNAPSHOT_O <= {LE_W{1'b0}};
    end else begin
      LINK_ERROR_EVENT_O <= BYTE_VALID_I && le_event;
      LINK_ERROR_COUNT_SNAPSHOT_O <= le_cnt;
      if (BYTE_VALID_I && flag_set)
        link_error_flag <= 1'b1;
      else if (BYTE_VALID_I && flag_clr)
        link_error_flag <= 1'b0;
      if (LINK_ERROR_RELOAD_I) begin
        le_cnt <= LINK_ERROR_THRESHOLD_I;
        LINK_ERROR_EXHAUSTED_O <= 1'b0;
      end else if (BYTE_VALID_I && le_event) begin
        if (le_cnt == {LE_W{1'b0}})
          LINK_ERROR_EXHAUSTED_O <= 1'b1;
        else
          le_cnt <= le_cnt - {{(LE_W-1){1'b0}}, 1'b1};
      end
    end
  end

endmodule // pcmc_monitor

// ---- tb/pcmc_monitor_chk.sv ----
// Port assertions for the monitor counters
`timescale 1ns/100ps
module pcmc_monitor_chk #(
  parameter CFG_W = 8,
  parameter LE_W = 16
) (
  // Clock, reset and inputs
  input wire REF_CLK_I,
  input wire RST_I,
  input wire TRIGGER_MET_I,
  input wire SCRUB_ON_TRIGGER_ENABLE_I,
  input wire [CFG_W-1:0] TRIGGER_TRANSITION_CONFIG_I,
  input wire [2:0] LINE_STATE_I,
  input wire LINK_ERROR_RELOAD_I,
  input wire [LE_W-1:0] LINK_ERROR_THRESHOLD_I,
  // Outputs
  input wire [7:0] INDICATE_O,
  input wire SCRUB_ACTIVE_O,
  input wire TRIGGER_OCCURRED_FLAG_O,
  input wire [CFG_W-1:0] SWITCH_CONFIGURATION_REGISTER_O,
  input wire EXTENDED_IDLE_STATE_O,
  input wire [LE_W-1:0] LINK_ERROR_COUNT_SNAPSHOT_O,
  input wire LINK_ERROR_EXHAUSTED_O
);
  // -----------------------------
  // One clock domain throughout
  // -----------------------------
  default clocking @(posedge REF_CLK_I); endclocking
  default disable iff (RST_I);
  property p_lead;
    $rose(SCRUB_ACTIVE_O) |-> INDICATE_O == 8'h3b ##1 INDICATE_O == 8'h3b ##1 INDICATE_O == 8'hb8;
  endproperty
  a_lead: assert property (p_lead) else $error("scrub lead-in wrong");
  property p_en;
    $rose(SCRUB_ACTIVE_O) |-> $past(SCRUB_ON_TRIGGER_ENABLE_I);
  endproperty
  a_en: assert property (p_en) else $error("scrub without enable");
  // Config must not move mid-scrub, the load comes only at the end
  property p_hold;
    SCRUB_ACTIVE_O && $past(SCRUB_ACTIVE_O) |-> $stable(SWITCH_CONFIGURATION_REGISTER_O);
  endproperty
  a_hold: assert property (p_hold) else $error("config changed in scrub");
  property p_end;
    $fell(SCRUB_ACTIVE_O) |-> SWITCH_CONFIGURATION_REGISTER_O == TRIGGER_TRANSITION_CONFIG_I;
  endproperty
  a_end: assert property (p_end) else $error("config not loaded after scrub");
  property p_flag;
    TRIGGER_MET_I |=> TRIGGER_OCCURRED_FLAG_O;
  endproperty
  a_flag: assert property (p_flag) else $error("trigger flag not set");
  property p_idle;
    $rose(EXTENDED_IDLE_STATE_O) |-> $past(LINE_STATE_I) == 3'h1;
  endproperty
  a_idle: assert property (p_idle) else $error("extended idle outside idle");
  property p_reload;
    LINK_ERROR_RELOAD_I |-> ##2 LINK_ERROR_COUNT_SNAPSHOT_O == $past(LINK_ERROR_THRESHOLD_I, 2);
  endproperty
  a_reload: assert property (p_reload) else $error("link count not reloaded");
  property p_exh;
    LINK_ERROR_EXHAUSTED_O && !LINK_ERROR_RELOAD_I |=> LINK_ERROR_EXHAUSTED_O;
  endproperty
  a_exh: assert property (p_exh) else $error("exhaustion dropped early");
endmodule // pcmc_monitor_chk
bind pcmc_monitor pcmc_monitor_chk #(.CFG_W(CFG_W), .LE_W(LE_W)) u_chk (
  .REF_CLK_I(REF_CLK_I), .RST_I(RST_I), .TRIGGER_MET_I(TRIGGER_MET_I),
  .SCRUB_ON_TRIGGER_ENABLE_I(SCRUB_ON_TRIGGER_ENABLE_I), .LINE_STATE_I(LINE_STATE_I),
  .TRIGGER_TRANSITION_CONFIG_I(TRIGGER_TRANSITION_CONFIG_I), .INDICATE_O(INDICATE_O),
  .LINK_ERROR_RELOAD_I(LINK_ERROR_RELOAD_I), .LINK_ERROR_THRESHOLD_I(LINK_ERROR_THRESHOLD_I),
  .SCRUB_ACTIVE_O(SCRUB_ACTIVE_O), .TRIGGER_OCCURRED_FLAG_O(TRIGGER_OCCURRED_FLAG_O),
  .SWITCH_CONFIGURATION_REGISTER_O(SWITCH_CONFIGURATION_REGISTER_O),
  .EXTENDED_IDLE_STATE_O(EXTENDED_IDLE_STATE_O), .LINK_ERROR_EXHAUSTED_O(LINK_ERROR_EXHAUSTED_O),
  .LINK_ERROR_COUNT_SNAPSHOT_O(LINK_ERROR_COUNT_SNAPSHOT_O));

// ---- tb/pcmc_line_model.sv ----
// Receive line-state detector model feeding bytes to the monitor
`timescale 1ns/100ps
module pcmc_line_model (
  // Clock
  input wire clk_i,
  // Byte stream
  output reg [2:0] ls_o,
  output reg [3:0] s1_o,
  output reg [3:0] s2_o,
  output reg c1_o,
  output reg c2_o,
  output reg bv_o,
  output reg sb_o
);
  // -----------------------------
  // Byte sender, called at a falling edge
  // -----------------------------
  initial begin
    {ls_o, s1_o, s2_o, c1_o, c2_o, bv_o, sb_o} = 15'h0;
  end
  // Symbols are scrambled once the byte is gone, so stale values never look valid
  task send(input [2:0] ls, input [3:0] a, input integer ca, input [3:0] b, input integer cb,
            input integer st);
    begin
      {ls_o, s1_o, c1_o, s2_o, c2_o, sb_o, bv_o} = {ls, a, ca[0], b, cb[0], st[0], 1'b1};
      @(negedge clk_i);
      {s1_o, s2_o, bv_o} = {~s1_o, ~s2_o, 1'b0};
      @(negedge clk_i);
    end
  endtask
endmodule // pcmc_line_model

// ---- tb/pcmc_monitor_tb_top.sv ----
// Self-checking testbench for the monitor counters
`timescale 1ns/100ps
`include "pcmc_regs.vh"
module pcmc_monitor_tb_top;
  // -----------------------------
  // Stimulus and observation
  // -----------------------------
  reg clk = 1'b0, rst = 1'b1, sd = 1'b1, cd = 1'b1, trig = 1'b0, tclr = 1'b0, en = 1'b0;
  reg cfg_wr = 1'b0, le_rl = 1'b0;
  reg [19:0] st_thr = 20'h02000;
  reg [7:0] ind = 8'h5a, trigger_transition_config = 8'h69, np_thr = 8'h01;
  reg [15:0] nc_thr = 16'h0002, le_thr = 16'h0003;
  wire [2:0] ls;
  wire [3:0] s1, s2;
  wire c1, c2, bv, sb, act, flag, xidle, nexp, nev, lev, lexh;
  wire [7:0] ind_o, st_snap, cfg_o, np_snap;
  wire [15:0] nc_snap, le_snap;
  integer n_errors = 0, total_checks = 0, i, k, n_ev = 0, n_le = 0, ev0 = 0, le0 = 0;
  initial forever #5 clk = ~clk;
  // Event pulses are tallied here so no task has to catch a single cycle
  always @(posedge clk) begin
    n_ev = n_ev + (nev === 1'b1);
    n_le = n_le + (lev === 1'b1);
  end
  pcmc_line_model line (.clk_i(clk), .ls_o(ls), .s1_o(s1), .s2_o(s2), .c1_o(c1), .c2_o(c2),
    .bv_o(bv), .sb_o(sb));
  pcmc_monitor dut (.REF_CLK_I(clk), .RST_I(rst), .LINE_STATE_I(ls), .SYM1_I(s1), .SYM2_I(s2),
    .SYM1_CTL_I(c1), .SYM2_CTL_I(c2), .BYTE_VALID_I(bv), .STUFFED_BYTE_I(sb),
    .SIGNAL_DETECT_I(sd), .CLOCK_DETECT_I(cd), .INDICATE_I(ind), .TRIGGER_MET_I(trig),
    .TRIGGER_FLAG_CLR_I(tclr), .SCRUB_ON_TRIGGER_ENABLE_I(en), .SCRUB_TIME_THRESHOLD_I(st_thr),
    .TRIGGER_TRANSITION_CONFIG_I(trigger_transition_config), .CFG_WDATA_I(8'h3c), .CFG_WRITE_I(cfg_wr),
    .NOISE_COUNT_THRESHOLD_I(nc_thr), .NOISE_PRESCALE_THRESHOLD_I(np_thr),
    .LINK_ERROR_THRESHOLD_I(le_thr), .LINK_ERROR_RELOAD_I(le_rl), .INDICATE_O(ind_o),
    .SCRUB_ACTIVE_O(act), .SCRUB_TIME_SNAPSHOT_O(st_snap), .TRIGGER_OCCURRED_FLAG_O(flag),
    .SWITCH_CONFIGURATION_REGISTER_O(cfg_o), .EXTENDED_IDLE_STATE_O(xidle),
    .NOISE_COUNT_SNAPSHOT_O(nc_snap), .NOISE_PRESCALE_SNAPSHOT_O(np_snap),
    .NOISE_EXPIRED_O(nexp), .NOISE_EVENT_O(nev), .LINK_ERROR_COUNT_SNAPSHOT_O(le_snap),
    .LINK_ERROR_EVENT_O(lev), .LINK_ERROR_EXHAUSTED_O(lexh));
  // -----------------------------
  // Shared tasks
  // -----------------------------
  task chk(input [31:0] seen, input [31:0] exp);
    begin
      total_checks = total_checks + 1;
      if (seen !== exp) begin
        n_errors = n_errors + 1;
        $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task close_out;
    begin
      if (n_errors == 0 && total_checks > 0) begin
        $display("SIMULATION PASSED");
      end else begin
        $display("SIMULATION FAILED");
      end
      $finish;
    end
  endtask
  // A wait that ran out of its bound ends the run as a failure
  task bound(input integer n, input integer lim);
    begin
      if (n >= lim) begin
        chk(n, 0);
        close_out;
      end
    end
  endtask
  // -----------------------------
  // Scenarios
  // -----------------------------
  task scrub_off;
    begin
      trig = 1'b1;
      @(negedge clk);
      trig = 1'b0;
      chk({flag, act}, 2'b10);
      @(negedge clk);
      chk({cfg_o, ind_o}, {trigger_transition_config, ind});
      {tclr, cfg_wr} = 2'b11;
      @(negedge clk);
      {tclr, cfg_wr} = 2'b00;
      chk({flag, cfg_o}, {1'b0, 8'h3c});
    end
  endtask
  // Software writes during the scrub must be refused
  task scrub_on;
    begin
      {en, trigger_transition_config, trig} = {1'b1, 8'ha5, 1'b1};
      @(negedge clk);
      {trig, cfg_wr, k} = {1'b0, 1'b1, 32'd0};
      for (i = 0; i < 9000 && act === 1'b1; i = i + 1) begin
        k = k + (ind_o === `PCMC_CODE_INVALID);
        if (i == 100) chk(st_snap, 8'h01);
        @(negedge clk);
      end
      cfg_wr = 1'b0;
      bound(i, 9000);
      chk(k, 2);
      // Two lead bytes, then threshold plus one scrub bytes, then the load byte
      chk(i, st_thr + 4);
      chk({cfg_o, ind_o}, {trigger_transition_config, ind});
    end
  endtask
  task idle_run;
    begin
      for (k = 0; k < 9; k = k + 1) line.send(`PCMC_LS_ILS, `PCMC_SYM_I, 1, `PCMC_SYM_I, 1, 0);
      chk(xidle, 0);
      line.send(`PCMC_LS_ILS, `PCMC_SYM_I, 1, `PCMC_SYM_I, 1, 0);
      chk(xidle, 1);
    end
  endtask
  // Expiry length is measured once, then a start delimiter must restart it
  task noise_run;
    begin
      line.send(`PCMC_LS_QLS, 4'h0, 1, 4'h0, 1, 0);
      chk({nc_snap, np_snap}, {nc_thr, np_thr});
      for (k = 0; k < 64 && nexp !== 1'b1; k = k + 1) line.send(`PCMC_LS_NLS, 4'h0, 1, 4'h0, 1, 0);
      bound(k, 64);
      line.send(`PCMC_LS_HLS, `PCMC_SYM_H, 1, `PCMC_SYM_H, 1, 0);
      chk(nexp, 0);
      for (i = 1; i < k; i = i + 1) line.send(`PCMC_LS_ALS, 4'h3, 0, 4'h4, 0, 0);
      line.send(`PCMC_LS_ALS, `PCMC_SYM_J, 1, `PCMC_SYM_K, 1, 0);
      for (i = 1; i < k; i = i + 1) line.send(`PCMC_LS_ALS, 4'h3, 0, 4'h4, 0, 0);
      chk(nexp, 0);
      line.send(`PCMC_LS_ALS, 4'h3, 0, 4'h4, 0, 0);
      chk(nexp, 1);
      line.send(`PCMC_LS_ILS, `PCMC_SYM_I, 1, `PCMC_SYM_I, 1, 0);
      ev0 = n_ev;
      line.send(`PCMC_LS_ALS, 4'h3, 0, 4'h4, 0, 0);
      line.send(`PCMC_LS_NLS, `PCMC_SYM_V, 1, `PCMC_SYM_V, 1, 0);
      chk(n_ev - ev0, 2);
      cd = 1'b0;
      repeat (4) @(negedge clk);
      // An idle pair is clean on its own, so only the lost clock can count it
      line.send(`PCMC_LS_ILS, `PCMC_SYM_I, 1, `PCMC_SYM_I, 1, 0);
      cd = 1'b1;
      chk(n_ev - ev0, 3);
      // Thresholds as software should set them: 71 x 71 bytes outlast a 4500-byte frame
      {nc_thr, np_thr} = {16'h0046, 8'h46};
      line.send(`PCMC_LS_ALS, `PCMC_SYM_J, 1, `PCMC_SYM_K, 1, 0);
      for (i = 0; i < 4499; i = i + 1) line.send(`PCMC_LS_ALS, 4'h3, 0, 4'h4, 0, 0);
      chk(nexp, 0);
    end
  endtask
  task link_run;
    begin
      le_rl = 1'b1;
      @(negedge clk);
      le_rl = 1'b0;
      le0 = n_le;
      line.send(`PCMC_LS_ILS, `PCMC_SYM_J, 1, `PCMC_SYM_K, 1, 0);
      line.send(`PCMC_LS_ALS, 4'h3, 0, 4'h4, 0, 0);
      line.send(`PCMC_LS_ALS, `PCMC_SYM_V, 1, 4'h3, 0, 0);
      chk(n_le - le0, 1);
      chk(le_snap, 16'h0002);
      line.send(`PCMC_LS_ALS, `PCMC_SYM_H, 1, `PCMC_SYM_H, 1, 0);
      line.send(`PCMC_LS_ULS, `PCMC_SYM_V, 1, `PCMC_SYM_V, 1, 1);
      chk(n_le - le0, 1);
      line.send(`PCMC_LS_ALS, `PCMC_SYM_H, 1, `PCMC_SYM_H, 1, 0);
      line.send(`PCMC_LS_ULS, `PCMC_SYM_V, 1, `PCMC_SYM_V, 1, 0);
      chk(n_le - le0, 2);
      line.send(`PCMC_LS_ALS, `PCMC_SYM_H, 1, `PCMC_SYM_H, 1, 0);
      line.send(`PCMC_LS_ALS, `PCMC_SYM_J, 1, `PCMC_SYM_K, 1, 0);
      line.send(`PCMC_LS_ULS, `PCMC_SYM_V, 1, `PCMC_SYM_V, 1, 0);
      chk(n_le - le0, 2);
      line.send(`PCMC_LS_ILS, `PCMC_SYM_I, 1, `PCMC_SYM_H, 1, 0);
      line.send(`PCMC_LS_ILS, `PCMC_SYM_V, 1, `PCMC_SYM_V, 1, 0);
      chk(n_le - le0, 4);
      chk({lexh, le_snap}, {1'b1, 16'h0000});
      le_rl = 1'b1;
      @(negedge clk);
      le_rl = 1'b0;
      chk(lexh, 0);
    end
  endtask
  // -----------------------------
  // Main sequence
  // -----------------------------
  initial begin
    repeat (16) @(negedge clk);
    rst = 1'b0;
    scrub_off;
    scrub_on;
    idle_run;
    noise_run;
    link_run;
    close_out;
  end
endmodule // pcmc_monitor_tb_top
